// >>> hw/current_scale_level_ctrl_regs.svh
// Register offsets, field positions, reset values and timing counts for core voltage scaling
`ifndef CURRENT_SCALE_LEVEL_CTRL_REGS_SVH
`define CURRENT_SCALE_LEVEL_CTRL_REGS_SVH
`define ADDR_POWER_CMD      8'h00
`define ADDR_POWER_STATUS   8'h04
`define ADDR_POWER_CTRL     8'h08
`define ADDR_EVENT_FLAGS    8'h0c
`define ADDR_EVENT_ENABLE   8'h10
`define ADDR_RETAIN_CTRL    8'h14
`define ADDR_RETAIN_STATUS  8'h18
`define ADDR_RETAIN_UNLOCK  8'h1c
`define CMD_HIGH_BIT        0
`define CMD_LOW_BIT         1
`define CTRL_SLEEP_LVL_BIT  0
`define CTRL_AUTOWS_BIT     1
`define CTRL_HIB_LVL_BIT    2
`define STAT_LEVEL_BIT      0
`define STAT_BUSY_BIT       1
`define LEVEL_HIGH          1'b1
`define LEVEL_LOW           1'b0
`define SCALE_TIME_NS       2000
`define CLK_PERIOD_NS       8
`define SCALE_CYCLES        (`SCALE_TIME_NS / `CLK_PERIOD_NS)
`define RC_FALLBACK_MHZ     19
`endif

// >>> hw/current_scale_level_ctrl_pkg.sv
// Types shared by the core voltage scaling controller
package current_scale_level_ctrl_pkg;
    typedef enum logic [1:0] {
        ST_ACTIVE = 2'b00,
        ST_SLEEP  = 2'b01,
        ST_HIB    = 2'b10
    } pmode_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } busReq_t;

    typedef struct packed {
        pmode_t      mode;
        logic        level;
        logic        target;
        logic        busy;
        logic [15:0] cnt;
        logic        doneFlag;
        logic        doneEn;
        logic        sleepLvl;
        logic        hibLvl;
        logic        autoWs;
        logic [7:0]  retainCtrl;
        logic        domainOff;
        logic        locked;
        logic [31:0] rdata;
        logic        fallback;
    } state_t;
endpackage : current_scale_level_ctrl_pkg

// >>> hw/current_scale_level_ctrl.sv
// Core voltage scaling controller with sleep levels and retention lockout
// Function
// - Active mode accepts high-level and low-level scale commands and starts scaling.
// - Busy bit set while scaling; current level always readable in status.
// - Both commands in one write: the low-level command wins.
// - Active level reads level 2 (high) after reset.
// - New command during scaling aborts it and runs the newest one.
// - Done flag set when scaling completes or a new command aborts it; none when soft reset, sleep or hibernate entry ends it.
// - Hard reset forces the level to level 2.
// - Soft reset keeps level; mid-scaling it applies the lower level.
// - Sleep entry applies the lower of active and sleep levels.
// - Sleep level field resets to level 2.
// - Wake from sleep keeps the reduced level.
// - Auto wait-state enable makes wake select 19 MHz RC and safe wait states.
// - Hibernate entry applies the smallest of active, sleep and hibernate levels.
// - Hibernate level resets to level 2; wake keeps the reduced level.
// - Sleep entry powers the domain down only if all peripherals disabled.
// - Powered-down peripherals are held in reset.
// - After wake, status shows power-down and peripheral access is blocked.
// - A write to the unlock register removes the lockout.
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/10ps
`include "current_scale_level_ctrl_regs.svh"
module current_scale_level_ctrl
    import current_scale_level_ctrl_pkg::*;
#(
    parameter int          NUM_PERIPH  = 8,
    parameter logic [15:0] SCALE_CYCLES = 16'(`SCALE_CYCLES)
) (
    // Clock and resets
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        softReset,
    // Register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [31:0] regRdata,
    // Energy mode requests from the core
    input  wire logic        sleepEnter,
    input  wire logic        hibEnter,
    input  wire logic        wakeUp,
    // Regulator and system side
    output logic             supplyLevel,
    output logic             scaleBusy,
    output logic             scaleIrq,
    output logic             rcFallback,
    output logic             periphPowerDown,
    output logic             periphReset,
    output logic             periphLocked
);
    busReq_t req;
    state_t  s_q;
    state_t  s_d;
    logic    wrCmd;
    logic    cmdHigh;
    logic    cmdLow;
    logic    newLevel;
    logic    sleepLevel;
    logic    hibLevel;
    logic    allOff;

    assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

    // Command decode and resolved mode levels
    always_comb begin
        wrCmd   = req.wr && (req.addr == `ADDR_POWER_CMD);
        cmdHigh = wrCmd && req.wdata[`CMD_HIGH_BIT];
        cmdLow  = wrCmd && req.wdata[`CMD_LOW_BIT];
        newLevel   = cmdLow ? `LEVEL_LOW : `LEVEL_HIGH;
        sleepLevel = s_q.level & s_q.sleepLvl;
        hibLevel   = s_q.level & s_q.sleepLvl & s_q.hibLvl;
        allOff     = &s_q.retainCtrl[NUM_PERIPH-1:0];
    end

    // Next-state logic
    always_comb begin
        s_d       = s_q;
        s_d.rdata = 32'h0;
        if (s_q.mode == ST_ACTIVE && (cmdHigh || cmdLow)) begin
            s_d.target = newLevel;
            s_d.busy   = 1'b1;
            s_d.cnt    = SCALE_CYCLES;
        end else if (s_q.busy) begin
            if (s_q.cnt <= 16'h1) begin
                s_d.busy  = 1'b0;
                s_d.level = s_q.target;
            end else begin
                s_d.cnt = s_q.cnt - 16'h1;
            end
        end
        if (s_q.busy && (cmdHigh || cmdLow) && s_q.mode == ST_ACTIVE) begin
            s_d.doneFlag = 1'b1;
        end else if (s_q.busy && s_q.cnt <= 16'h1) begin
            s_d.doneFlag = 1'b1;
        end else if (req.wr && req.addr == `ADDR_EVENT_FLAGS && req.wdata[0]) begin
            s_d.doneFlag = 1'b0;
        end
        // Mode transitions
        case (s_q.mode)
            ST_ACTIVE: begin
                if (hibEnter) begin
                    s_d.mode  = ST_HIB;
                    s_d.level = hibLevel;
                    s_d.busy  = 1'b0;
                end else if (sleepEnter) begin
                    s_d.mode  = ST_SLEEP;
                    s_d.level = sleepLevel;
                    s_d.busy  = 1'b0;
                    s_d.domainOff = allOff;
                end
            end
            ST_SLEEP, ST_HIB: begin
                if (wakeUp) begin
                    s_d.mode = ST_ACTIVE;
                    s_d.fallback = s_q.autoWs;
                    if (s_q.domainOff) begin
                        s_d.locked    = 1'b1;
                        s_d.domainOff = 1'b0;
                    end
                end
            end
            default: s_d.mode = ST_ACTIVE;
        endcase
        // Register writes
        if (req.wr) begin
            if (req.addr == `ADDR_POWER_CTRL) begin
                s_d.sleepLvl = req.wdata[`CTRL_SLEEP_LVL_BIT];
                s_d.autoWs   = req.wdata[`CTRL_AUTOWS_BIT];
                s_d.hibLvl   = req.wdata[`CTRL_HIB_LVL_BIT];
                // A fallback raised by this same wake wins over the clear
                if (!(s_q.mode != ST_ACTIVE && wakeUp)) begin
                    s_d.fallback = 1'b0;
                end
            end else if (req.addr == `ADDR_EVENT_ENABLE) begin
                s_d.doneEn = req.wdata[0];
            end else if (req.addr == `ADDR_RETAIN_CTRL) begin
                s_d.retainCtrl = req.wdata[7:0];
            end else if (req.addr == `ADDR_RETAIN_UNLOCK) begin
                // unlock, a lock set by the same wake wins
                if (!(s_q.domainOff && wakeUp)) begin
                    s_d.locked = 1'b0;
                end
            end
        end
        // Register reads, data valid next cycle
        if (req.rd) begin
            if (req.addr == `ADDR_POWER_STATUS) begin
                s_d.rdata = {30'h0, s_q.busy, s_q.level};
            end else if (req.addr == `ADDR_POWER_CTRL) begin
                s_d.rdata = {29'h0, s_q.hibLvl, s_q.autoWs, s_q.sleepLvl};
            end else if (req.addr == `ADDR_EVENT_FLAGS) begin
                s_d.rdata = {31'h0, s_q.doneFlag};
            end else if (req.addr == `ADDR_EVENT_ENABLE) begin
                s_d.rdata = {31'h0, s_q.doneEn};
            end else if (req.addr == `ADDR_RETAIN_CTRL) begin
                s_d.rdata = {24'h0, s_q.retainCtrl};
            end else if (req.addr == `ADDR_RETAIN_STATUS) begin
                s_d.rdata = {31'h0, s_q.locked};
            end else begin
                s_d.rdata = 32'h0;
            end
        end
        if (softReset) begin
            if (s_q.busy) begin
                s_d.level = s_q.level & s_q.target;
            end
            s_d.busy = 1'b0;
            s_d.cnt  = 16'h0;
        end
    end

    // State register, reset to level 2
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            s_q <= '{mode: ST_ACTIVE, level: `LEVEL_HIGH, target: `LEVEL_HIGH,
                     busy: 1'b0, cnt: 16'h0, doneFlag: 1'b0, doneEn: 1'b0,
                     sleepLvl: `LEVEL_HIGH, hibLvl: `LEVEL_HIGH, autoWs: 1'b0,
                     retainCtrl: 8'h00, domainOff: 1'b0, locked: 1'b0,
                     rdata: 32'h0, fallback: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs
    assign regRdata        = s_q.rdata;
    assign supplyLevel     = s_q.level;
    assign scaleBusy       = s_q.busy;
    assign scaleIrq        = s_q.doneFlag & s_q.doneEn;
    assign rcFallback      = s_q.fallback;
    assign periphPowerDown = s_q.domainOff;
    assign periphReset     = s_q.domainOff;
    assign periphLocked    = s_q.locked;

    // Assertions
    property p_busy_ends;
        @(posedge clk_sys) disable iff (reset || softReset)
        $rose(scaleBusy) && !(regWr && regAddr == `ADDR_POWER_CMD) |-> ##[1:300] !scaleBusy;
    endproperty
    a_busy_ends: assert property (p_busy_ends) else $error("busy stuck");

    property p_low_wins;
        @(posedge clk_sys) disable iff (reset || softReset)
        s_q.mode == ST_ACTIVE && regWr && regAddr == `ADDR_POWER_CMD && regWdata[1:0] == 2'b11
        && !sleepEnter && !hibEnter |=> s_q.target == `LEVEL_LOW && scaleBusy;
    endproperty
    a_low_wins: assert property (p_low_wins) else $error("low cmd lost");

    property p_cmd_starts;
        @(posedge clk_sys) disable iff (reset || softReset)
        s_q.mode == ST_ACTIVE && regWr && regAddr == `ADDR_POWER_CMD && regWdata[1:0] != 2'b00
        && !sleepEnter && !hibEnter |=> scaleBusy && s_q.cnt == SCALE_CYCLES;
    endproperty
    a_cmd_starts: assert property (p_cmd_starts) else $error("no scaling start");

    property p_abort_done;
        @(posedge clk_sys) disable iff (reset || softReset)
        scaleBusy && s_q.mode == ST_ACTIVE && regWr && regAddr == `ADDR_POWER_CMD
        && regWdata[1:0] != 2'b00 |=> s_q.doneFlag;
    endproperty
    a_abort_done: assert property (p_abort_done) else $error("abort done missing");

    property p_irq_gate;
        @(posedge clk_sys) disable iff (reset)
        regWr && regAddr == `ADDR_EVENT_ENABLE && !regWdata[0] |=> !scaleIrq;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq not gated");

    property p_sleep_min;
        @(posedge clk_sys) disable iff (reset || softReset)
        s_q.mode == ST_ACTIVE && sleepEnter && !hibEnter
        |=> supplyLevel == ($past(s_q.level) & $past(s_q.sleepLvl));
    endproperty
    a_sleep_min: assert property (p_sleep_min) else $error("sleep level wrong");

    property p_hib_min;
        @(posedge clk_sys) disable iff (reset || softReset)
        s_q.mode == ST_ACTIVE && hibEnter
        |=> supplyLevel == ($past(s_q.level) & $past(s_q.sleepLvl) & $past(s_q.hibLvl));
    endproperty
    a_hib_min: assert property (p_hib_min) else $error("hibernate level wrong");

    property p_wake_keep;
        @(posedge clk_sys) disable iff (reset || softReset)
        s_q.mode != ST_ACTIVE && wakeUp |=> $stable(supplyLevel);
    endproperty
    a_wake_keep: assert property (p_wake_keep) else $error("wake changed level");

    property p_unlock;
        @(posedge clk_sys) disable iff (reset)
        regWr && regAddr == `ADDR_RETAIN_UNLOCK && !(s_q.mode != ST_ACTIVE && wakeUp)
        |=> !periphLocked;
    endproperty
    a_unlock: assert property (p_unlock) else $error("lockout kept");

    property p_soft_min;
        @(posedge clk_sys) disable iff (reset)
        softReset && scaleBusy |=> supplyLevel == ($past(s_q.level) & $past(s_q.target));
    endproperty
    a_soft_min: assert property (p_soft_min) else $error("soft reset level wrong");

    property p_soft_keep;
        @(posedge clk_sys) disable iff (reset)
        softReset && !scaleBusy && !(s_q.mode == ST_ACTIVE && (sleepEnter || hibEnter))
        |=> $stable(supplyLevel);
    endproperty
    a_soft_keep: assert property (p_soft_keep) else $error("idle soft reset moved level");

    property p_done_sticky;
        @(posedge clk_sys) disable iff (reset)
        s_q.doneFlag && !(regWr && regAddr == `ADDR_EVENT_FLAGS && regWdata[0]) |=> s_q.doneFlag;
    endproperty
    a_done_sticky: assert property (p_done_sticky) else $error("done flag lost");

    property p_lock_wake;
        @(posedge clk_sys) disable iff (reset)
        s_q.mode != ST_ACTIVE && wakeUp && periphPowerDown |=> periphLocked;
    endproperty
    a_lock_wake: assert property (p_lock_wake) else $error("no lockout after wake");

    property p_domain_off;
        @(posedge clk_sys) disable iff (reset)
        s_q.mode == ST_ACTIVE && sleepEnter && !hibEnter
        |=> periphPowerDown == (&$past(s_q.retainCtrl));
    endproperty
    a_domain_off: assert property (p_domain_off) else $error("domain power-down wrong");

    property p_fallback_wake;
        @(posedge clk_sys) disable iff (reset)
        s_q.mode != ST_ACTIVE && wakeUp |=> rcFallback == $past(s_q.autoWs);
    endproperty
    a_fallback_wake: assert property (p_fallback_wake) else $error("fallback wrong");
endmodule : current_scale_level_ctrl

// >>> verif/tb.sv
// Self-checking testbench for the core voltage scaling controller
`timescale 1ns/10ps
`include "current_scale_level_ctrl_regs.svh"
module tb;
    import current_scale_level_ctrl_pkg::*;
    localparam logic [15:0] SC = 16'h0008;  // Short scaling time for simulation
    logic        clk_sys = 1'b0, reset = 1'b1, softReset = 1'b0;
    logic        regWr = 1'b0, regRd = 1'b0;
    logic        sleepEnter = 1'b0, hibEnter = 1'b0, wakeUp = 1'b0;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0, regRdata, rv;
    logic        supplyLevel, scaleBusy, scaleIrq, rcFallback;
    logic        periphPowerDown, periphReset, periphLocked;
    int          nFail = 0, numChecks = 0;

    current_scale_level_ctrl #(.SCALE_CYCLES(SC)) u_dut (
        .clk_sys(clk_sys), .reset(reset), .softReset(softReset), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .sleepEnter(sleepEnter), .hibEnter(hibEnter), .wakeUp(wakeUp),
        .supplyLevel(supplyLevel), .scaleBusy(scaleBusy), .scaleIrq(scaleIrq),
        .rcFallback(rcFallback), .periphPowerDown(periphPowerDown),
        .periphReset(periphReset), .periphLocked(periphLocked));

    // 125 MHz system clock
    always #4 clk_sys = ~clk_sys;

    task automatic printVerdict();
        $display("checks %0d mismatches %0d", numChecks, nFail);
        if (nFail == 0 && numChecks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : printVerdict

    task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            nFail++;
            $display("mismatch at %0t: register got %h expected %h", $time, got, exp);
        end
    endtask : chkReg

    task automatic chkPin(input logic got, input logic exp);
        numChecks++;
        if (got !== exp) begin
            nFail++;
            $display("mismatch at %0t: pin got %b expected %b", $time, got, exp);
        end
    endtask : chkPin

    // One-cycle write, effect visible after return
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regWr <= 1'b1; regAddr <= a; regWdata <= d;
        @(posedge clk_sys);
        regWr <= 1'b0;
        #1;
    endtask : wr

    // One-cycle read, data taken in the following cycle
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        regRd <= 1'b1; regAddr <= a;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1;
        d = regRdata;
    endtask : rd

    // Pulse a mode pin: 0 sleep, 1 hibernate, 2 wake, 3 soft reset
    task automatic pulse(input int k);
        @(posedge clk_sys);
        sleepEnter <= (k == 0); hibEnter <= (k == 1); wakeUp <= (k == 2); softReset <= (k == 3);
        @(posedge clk_sys);
        {sleepEnter, hibEnter, wakeUp, softReset} <= 4'h0;
        #1;
    endtask : pulse

    task automatic waitIdle();
        int i;
        for (i = 0; i < 50 && scaleBusy !== 1'b0; i++) begin
            @(posedge clk_sys);
            #1;
        end
        if (scaleBusy !== 1'b0) begin
            nFail++;
            $display("mismatch at %0t: scaling never finished", $time);
            printVerdict();
        end
    endtask : waitIdle

    task automatic hardReset();
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        #1;
    endtask : hardReset

    task automatic testResetValues();
        chkPin(supplyLevel, 1'b1);
        rd(`ADDR_POWER_STATUS, rv); chkReg(rv, 32'h1);
        rd(`ADDR_POWER_CTRL, rv); chkReg(rv, 32'h5);
        rd(8'h20, rv); chkReg(rv, 32'h0);
        $display("test reset values done");
    endtask : testResetValues

    task automatic testBothCmds();
        wr(`ADDR_POWER_CMD, 32'h3);
        chkPin(scaleBusy, 1'b1);
        rd(`ADDR_POWER_STATUS, rv); chkReg(rv, 32'h3);
        waitIdle();
        chkPin(supplyLevel, 1'b0);
        chkPin(scaleIrq, 1'b0);
        wr(`ADDR_EVENT_ENABLE, 32'h1); chkPin(scaleIrq, 1'b1);
        wr(`ADDR_EVENT_ENABLE, 32'h0); chkPin(scaleIrq, 1'b0);
        wr(`ADDR_EVENT_ENABLE, 32'h1); chkPin(scaleIrq, 1'b1);
        wr(`ADDR_EVENT_FLAGS, 32'h1); chkPin(scaleIrq, 1'b0);
        $display("test both commands done");
    endtask : testBothCmds

    task automatic testAbort();
        wr(`ADDR_POWER_CMD, 32'h1);
        wr(`ADDR_POWER_CMD, 32'h2);
        rd(`ADDR_EVENT_FLAGS, rv); chkReg(rv, 32'h1);
        wr(`ADDR_EVENT_FLAGS, 32'h1);
        rd(`ADDR_EVENT_FLAGS, rv); chkReg(rv, 32'h0);
        waitIdle();
        chkPin(supplyLevel, 1'b0);
        rd(`ADDR_EVENT_FLAGS, rv); chkReg(rv, 32'h1);
        $display("test abort done");
    endtask : testAbort

    task automatic testSoftReset();
        wr(`ADDR_POWER_CMD, 32'h1);
        waitIdle();
        chkPin(supplyLevel, 1'b1);
        pulse(3); chkPin(supplyLevel, 1'b1);
        wr(`ADDR_POWER_CMD, 32'h2);
        pulse(3);
        chkPin(supplyLevel, 1'b0);
        chkPin(scaleBusy, 1'b0);
        rd(`ADDR_POWER_STATUS, rv); chkReg(rv, 32'h0);
        hardReset(); chkPin(supplyLevel, 1'b1);
        $display("test soft reset done");
    endtask : testSoftReset

    task automatic testSleep();
        wr(`ADDR_POWER_CTRL, 32'h6);
        wr(`ADDR_RETAIN_CTRL, 32'hff);
        pulse(0);
        chkPin(supplyLevel, 1'b0);
        chkPin(periphPowerDown, 1'b1);
        chkPin(periphReset, 1'b1);
        pulse(2);
        chkPin(supplyLevel, 1'b0);
        chkPin(periphLocked, 1'b1);
        chkPin(rcFallback, 1'b1);
        rd(`ADDR_RETAIN_STATUS, rv); chkReg(rv, 32'h1);
        wr(`ADDR_RETAIN_UNLOCK, 32'h0); chkPin(periphLocked, 1'b0);
        wr(`ADDR_POWER_CTRL, 32'h1); chkPin(rcFallback, 1'b0);
        wr(`ADDR_RETAIN_CTRL, 32'hfe);
        pulse(0);
        chkPin(supplyLevel, 1'b0);
        chkPin(periphPowerDown, 1'b0);
        pulse(2); chkPin(periphLocked, 1'b0);
        $display("test sleep done");
    endtask : testSleep

    task automatic testHibernate();
        hardReset();
        wr(`ADDR_POWER_CTRL, 32'h1);
        pulse(1); chkPin(supplyLevel, 1'b0);
        pulse(2); chkPin(supplyLevel, 1'b0);
        $display("test hibernate done");
    endtask : testHibernate

    initial begin
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        #1;
        testResetValues();
        testBothCmds();
        testAbort();
        testSoftReset();
        testSleep();
        testHibernate();
        printVerdict();
    end
endmodule : tb
